// ===== design/ufc_params.svh
// constants for the flow, trigger and divisor register block
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// ****************************************
// register addresses on the parallel bus
// ****************************************
`define UFC_ADDR_EFR 3'h0
`define UFC_ADDR_DLL 3'h1
`define UFC_ADDR_DLH 3'h2
`define UFC_ADDR_TCR 3'h3
`define UFC_ADDR_TLR 3'h4
`define UFC_ADDR_IER 3'h5
`define UFC_ADDR_MCR 3'h6
`define UFC_ADDR_RDY 3'h7
// ****************************************
// field positions
// ****************************************
`define UFC_EFR_WEN 4
`define UFC_EFR_SPECIAL 5
`define UFC_EFR_AUTO_RTS 6
`define UFC_EFR_AUTO_CTS 7
`define UFC_IER_SLEEP 4
`define UFC_MCR_RTS 1
`define UFC_MCR_RDY_EN 2
`define UFC_MCR_LOOP 4
`define UFC_MCR_LVL_EN 6
// ****************************************
// reset values and fallback trigger levels
// ****************************************
`define UFC_REG_RESET 8'h00
`define UFC_FCR_LVL0 7'h08
`define UFC_FCR_LVL1 7'h10
`define UFC_FCR_LVL2 7'h20
`define UFC_FCR_LVL3 7'h38
`endif

// ===== design/ufc_pkg.sv
// types for the flow, trigger and divisor register block
package ufc_pkg;
  // synchronised bus pins
  typedef struct packed {
    logic cs_a_n;
    logic cs_b_n;
    logic wr_n;
    logic rd_n;
    logic [2:0] addr;
    logic [7:0] data;
  } ufc_bus_t;
  // per channel registers and flags
  typedef struct packed {
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] dll;
    logic [7:0] baud_divisor_high;
    logic [7:0] flow_threshold_ctrl;
    logic [7:0] fifo_trigger_ctrl;
    logic [7:0] interrupt_enable_ctrl;
    logic [7:0] modem_control;
    logic [7:0] fifo_control;
    logic rts;
    logic tx_halt;
    logic special;
  } ufc_chan_t;
  // whole module state
  typedef struct packed {
    ufc_bus_t s1;
    ufc_bus_t s2;
    ufc_bus_t s3;
    logic [1:0] cts_s1;
    logic [1:0] cts_s2;
    ufc_chan_t [1:0] ch;
    logic [7:0] rdata;
    logic rdata_oe;
    logic [7:0] ready;
  } ufc_state_t;
endpackage

// ===== design/ufc_top.sv
// dual channel flow control, trigger level, divisor and fifo ready logic
`timescale 1ns/1ps
`include "ufc_params.svh"
module ufc_top
  import ufc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [1:0] cts_i,
  input wire logic [13:0] rx_count_i,
  input wire logic [13:0] tx_free_i,
  input wire logic [1:0] rx_timeout_i,
  input wire logic [1:0] rx_valid_i,
  input wire logic [15:0] rx_char_i,
  input wire logic [15:0] xoff2_char_i,
  input wire logic [1:0] special_clear_i,
  output logic [1:0] rts_o,
  output logic [1:0] tx_halt_o,
  output logic [1:0] special_o,
  output logic [7:0] sw_flow_mode_o,
  output logic [31:0] baud_divisor_o,
  output logic [1:0] sleep_o,
  output logic [1:0] loopback_o,
  output logic [7:0] fifo_ready_status_o
);

  // ****************************************
  // overview
  // ****************************************
  // two channels share one bus; each chip select picks its own register set
  // both selects low make a write land in both channels at once
  // a read with both selects low is answered by channel a only
  // bus pins pass two flops, then a third stage keeps the older sample
  // a write is taken when the synchronised strobe is seen to rise
  // the address and data of a write come from the stage behind the release,
  // so they need only be steady while the strobe is low and may change as soon as it goes high
  // a read answers every cycle while the strobe and a select stay low
  // read data and its enable are registered and drop to zero when idle
  // cts pins pass two flops before the halt logic reads them
  // fifo counts, timeouts and received characters come from logic on this
  // clock and are read directly, with no synchroniser
  // per channel state: feature, divisor, threshold, trigger, enable,
  // modem and fifo control registers, plus the rts, halt and match flags
  // the feature write bit gates the upper bits of enable and modem control and bits 5:4 of fifo
  // control; threshold and trigger also need the modem level bit
  // divisor bytes only change while sleep is off
  // rts is the inverse of the modem control bit unless automatic rts is on, and then
  // rises at the halt level and falls at the restore level, holding between
  // the block does not check that halt sits above restore; a host that
  // programs them the other way round gets rts high at or above halt and low below it
  // a zero trigger nibble falls back to the fixed fifo control levels
  // the ready status word is rebuilt every cycle from the live counts
  // the match flag is sticky: a match in the same cycle as a clear wins
  // all outputs come straight from the state register

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_q; // reset release chain
  logic rst_n; // synchronised reset

  // the pin reset asserts at once but leaves on a clock edge,
  // so no state flop sees its release close to a clock edge
  // the state register uses only this released copy
  // reset leaves through two flip-flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ****************************************
  // helpers
  // ****************************************
  // nibble level scaled to a fifo count
  function automatic logic [6:0] lvl4(input logic [3:0] l);
    lvl4 = {1'b0, l, 2'b00};
  endfunction

  // the four fixed levels cover the range a zero nibble falls back to
  // changing them here changes both directions alike
  // fallback level from a two bit fifo control field
  function automatic logic [6:0] fcr_lvl(input logic [1:0] sel);
    case (sel)
      2'd0: fcr_lvl = `UFC_FCR_LVL0;
      2'd1: fcr_lvl = `UFC_FCR_LVL1;
      2'd2: fcr_lvl = `UFC_FCR_LVL2;
      default: fcr_lvl = `UFC_FCR_LVL3;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  ufc_state_t st; // registered state
  ufc_state_t next_st; // next state
  ufc_bus_t pins; // raw bus pins
  logic wr_take; // write strobe released this cycle
  logic [1:0] wr_sel; // channels addressed by the write
  logic rd_act; // read strobe active with a select
  logic rd_ch; // channel answering a read

  assign pins = '{chip_select_a_n_i, chip_select_b_n_i, wr_n_i, rd_n_i, addr_i, data_i};
  // the release edge is seen between the second and third stage, so the
  // third stage still holds the fields sampled while the strobe was low
  // a stuck low strobe never writes; it only writes when let go
  // write taken on release of the strobe, fields from the stage behind
  assign wr_take = st.s2.wr_n && !st.s3.wr_n;
  assign wr_sel = {!st.s3.cs_b_n, !st.s3.cs_a_n};
  assign rd_act = !st.s2.rd_n && (!st.s2.cs_a_n || !st.s2.cs_b_n);
  assign rd_ch = st.s2.cs_a_n;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [6:0] rxc;
    logic [6:0] txf;
    logic [6:0] rx_trig;
    logic [6:0] tx_trig;
    logic gate;
    ufc_chan_t c;
    rxc = '0;
    txf = '0;
    rx_trig = '0;
    tx_trig = '0;
    gate = 1'b0;
    c = '0;
    next_st = st;
    // every field keeps its value unless a branch below changes it
    // the loop below handles both channels with the same logic
    // the temporaries above are cleared first so nothing is inferred as a latch
    // pin synchronisers, first stage feeds only the second
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.cts_s1 = cts_i;
    next_st.cts_s2 = st.cts_s1;
    next_st.ready = 8'h00; // unused bits stay zero
    for (int i = 0; i < 2; i++) begin
      c = st.ch[i];
      rxc = rx_count_i[i*7 +: 7];
      txf = tx_free_i[i*7 +: 7];
      // gate and level enable are read from the registers as they stood
      // before this write, so a write that sets the gate does not also
      // open itself for the same cycle
      // lower bits of the enable, modem and fifo control registers are always writable
      // host writes into this channel
      if (wr_take && wr_sel[i]) begin
        gate = st.ch[i].enhanced_feature_ctrl[`UFC_EFR_WEN];
        if (st.s3.addr == `UFC_ADDR_EFR) begin
          c.enhanced_feature_ctrl = st.s3.data;
        end else if (st.s3.addr == `UFC_ADDR_DLL) begin
          if (!st.ch[i].interrupt_enable_ctrl[`UFC_IER_SLEEP]) begin
            c.dll = st.s3.data;
          end
        end else if (st.s3.addr == `UFC_ADDR_DLH) begin
          if (!st.ch[i].interrupt_enable_ctrl[`UFC_IER_SLEEP]) begin
            c.baud_divisor_high = st.s3.data;
          end
        end else if (st.s3.addr == `UFC_ADDR_TCR) begin
          if (gate && st.ch[i].modem_control[`UFC_MCR_LVL_EN]) begin
            c.flow_threshold_ctrl = st.s3.data;
          end
        end else if (st.s3.addr == `UFC_ADDR_TLR) begin
          if (gate && st.ch[i].modem_control[`UFC_MCR_LVL_EN]) begin
            c.fifo_trigger_ctrl = st.s3.data;
          end
        end else if (st.s3.addr == `UFC_ADDR_IER) begin
          c.interrupt_enable_ctrl[3:0] = st.s3.data[3:0];
          if (gate) begin
            c.interrupt_enable_ctrl[7:4] = st.s3.data[7:4];
          end
        end else if (st.s3.addr == `UFC_ADDR_MCR) begin
          c.modem_control[4:0] = st.s3.data[4:0];
          if (gate) begin
            c.modem_control[7:5] = st.s3.data[7:5];
          end
        end else begin
          // address 7 writes the fifo control register
          c.fifo_control[3:0] = st.s3.data[3:0];
          c.fifo_control[7:6] = st.s3.data[7:6];
          if (gate) begin
            c.fifo_control[5:4] = st.s3.data[5:4];
          end
        end
      end
      // halt is tested first, so a halt level at or below restore leaves
      // rts high whenever the count reaches halt
      // between the two levels the previous rts value is kept
      // with automatic rts off the modem control bit forces the level
      // auto rts hysteresis on the receive count
      if (st.ch[i].enhanced_feature_ctrl[`UFC_EFR_AUTO_RTS]) begin
        if (rxc >= lvl4(st.ch[i].flow_threshold_ctrl[3:0])) begin
          c.rts = 1'b1;
        end else if (rxc <= lvl4(st.ch[i].flow_threshold_ctrl[7:4])) begin
          c.rts = 1'b0;
        end
      end else begin
        c.rts = !st.ch[i].modem_control[`UFC_MCR_RTS]; // forced level, active low
      end
      // uses the second synchroniser stage only; one extra cycle of delay
      // cts halts the transmitter while high
      c.tx_halt = st.ch[i].enhanced_feature_ctrl[`UFC_EFR_AUTO_CTS] && st.cts_s2[i];
      // the character is still stored by the receive path; only a flag is raised
      // the flag stays up until the interrupt side clears it
      // special character detect, set beats clear
      if (st.ch[i].enhanced_feature_ctrl[`UFC_EFR_SPECIAL] && rx_valid_i[i] && rx_char_i[i*8 +: 8] == xoff2_char_i[i*8 +: 8]) begin
        c.special = 1'b1;
      end else if (special_clear_i[i]) begin
        c.special = 1'b0;
      end
      // each nibble is checked on its own, so one direction may use the
      // programmed level while the other falls back
      // effective trigger levels
      if (st.ch[i].fifo_trigger_ctrl[7:4] != 4'h0) begin
        rx_trig = lvl4(st.ch[i].fifo_trigger_ctrl[7:4]);
      end else begin
        rx_trig = fcr_lvl(st.ch[i].fifo_control[7:6]);
      end
      if (st.ch[i].fifo_trigger_ctrl[3:0] != 4'h0) begin
        tx_trig = lvl4(st.ch[i].fifo_trigger_ctrl[3:0]);
      end else begin
        tx_trig = fcr_lvl(st.ch[i].fifo_control[5:4]);
      end
      next_st.ready[i] = txf >= tx_trig;
      next_st.ready[i+4] = (rxc > rx_trig) || rx_timeout_i[i];
      next_st.ch[i] = c;
    end
    // address seven reads the ready word only when the answering channel
    // has the ready enable bit set and is not in local loopback
    // otherwise that address reads as zero, as does an idle bus
    // the decode uses the second stage, one cycle ahead of the write decode
    // read path, channel a answers when both are selected
    next_st.rdata_oe = rd_act;
    next_st.rdata = 8'h00;
    if (rd_act) begin
      if (st.s2.addr == `UFC_ADDR_EFR) begin
        next_st.rdata = st.ch[rd_ch].enhanced_feature_ctrl;
      end else if (st.s2.addr == `UFC_ADDR_DLL) begin
        next_st.rdata = st.ch[rd_ch].dll;
      end else if (st.s2.addr == `UFC_ADDR_DLH) begin
        next_st.rdata = st.ch[rd_ch].baud_divisor_high;
      end else if (st.s2.addr == `UFC_ADDR_TCR) begin
        next_st.rdata = st.ch[rd_ch].flow_threshold_ctrl;
      end else if (st.s2.addr == `UFC_ADDR_TLR) begin
        next_st.rdata = st.ch[rd_ch].fifo_trigger_ctrl;
      end else if (st.s2.addr == `UFC_ADDR_IER) begin
        next_st.rdata = st.ch[rd_ch].interrupt_enable_ctrl;
      end else if (st.s2.addr == `UFC_ADDR_MCR) begin
        next_st.rdata = st.ch[rd_ch].modem_control;
      end else if (st.ch[rd_ch].modem_control[`UFC_MCR_RDY_EN] && !st.ch[rd_ch].modem_control[`UFC_MCR_LOOP]) begin
        next_st.rdata = st.ready;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // bus stages reset to the idle level so no false strobe follows reset
  // rts resets high, the halted level, until software sets it up
  // every other field clears to zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.s1 <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
      st.s2 <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
      st.s3 <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
      st.ch[0].enhanced_feature_ctrl <= `UFC_REG_RESET;
      st.ch[1].enhanced_feature_ctrl <= `UFC_REG_RESET;
      st.ch[0].rts <= 1'b1;
      st.ch[1].rts <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  // each output is a plain wire from a state flop, no logic in between
  // the channel outputs are packed with channel a in the low bits
  // divisor words are high byte above low byte per channel
  assign data_o = st.rdata;
  assign data_oe_o = st.rdata_oe;
  assign fifo_ready_status_o = st.ready;
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign rts_o[g] = st.ch[g].rts;
    assign tx_halt_o[g] = st.ch[g].tx_halt;
    assign special_o[g] = st.ch[g].special;
    assign sw_flow_mode_o[g*4 +: 4] = st.ch[g].enhanced_feature_ctrl[3:0];
    assign baud_divisor_o[g*16 +: 16] = {st.ch[g].baud_divisor_high, st.ch[g].dll};
    assign sleep_o[g] = st.ch[g].interrupt_enable_ctrl[`UFC_IER_SLEEP];
    assign loopback_o[g] = st.ch[g].modem_control[`UFC_MCR_LOOP];
  end

endmodule // ufc_top

// ===== verification/uart_flow_trigger_config_test.sv
// self-checking bench for the flow, trigger and divisor block
`timescale 1ns/1ps
`include "ufc_params.svh"
module uart_flow_trigger_config_test;
  import ufc_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic chip_select_a_n_i, chip_select_b_n_i, wr_n_i, rd_n_i, data_oe_o;
  logic [2:0] addr_i;
  logic [7:0] data_i, data_o, q, sw_flow_mode_o, fifo_ready_status_o;
  logic [1:0] cts_i = '0, rx_timeout_i = '0, rx_valid_i = '0, special_clear_i = '0;
  logic [1:0] rts_o, tx_halt_o, special_o, sleep_o, loopback_o;
  logic [13:0] rx_count_i = '0, tx_free_i = 14'h1e3c;
  logic [15:0] rx_char_i = '0, xoff2_char_i = 16'h0013;
  logic [31:0] baud_divisor_o;
  logic [6:0] lv [5] = '{7'h10, 7'h27, 7'h28, 7'h11, 7'h10};
  logic ex [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int n_fail = 0;
  int compares = 0;
  ufc_top i_dut (.*);
  ufc_host i_host (.clk_i(clk_i), .rdata_i(data_o), .cs_a_n_o(chip_select_a_n_i), .cs_b_n_o(chip_select_b_n_i),
                   .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .addr_o(addr_i), .data_o(data_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    i_host.go(s, a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e);
    i_host.go(s, a, 8'h00, 1'b0, q);
    chk(q, e);
  endtask
  task automatic rc(input logic [1:0] s, input logic [7:0] e);
    rd(s, `UFC_ADDR_RDY, e);
  endtask
  task automatic pv(input logic [7:0] c);
    rx_char_i[7:0] = c;
    rx_valid_i[0] = 1'b1;
    @(negedge clk_i);
    rx_valid_i[0] = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    tally_and_finish;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    chk({rts_o, baud_divisor_o[15:0], sw_flow_mode_o}, 32'h030000_00);
    wr(2'h1, `UFC_ADDR_EFR, 8'h15);
    wr(2'h1, `UFC_ADDR_DLL, 8'h34);
    wr(2'h1, `UFC_ADDR_DLH, 8'h12);
    wr(2'h1, `UFC_ADDR_IER, 8'h10);
    wr(2'h1, `UFC_ADDR_DLL, 8'h56);
    chk(sw_flow_mode_o, 8'h05);
    chk(baud_divisor_o, 32'h00001234);
    rd(2'h1, `UFC_ADDR_DLL, 8'h34);
    rd(2'h1, `UFC_ADDR_EFR, 8'h15);
    $display("test divisor done");
    wr(2'h2, `UFC_ADDR_IER, 8'h10);
    wr(2'h2, `UFC_ADDR_MCR, 8'h14);
    chk({loopback_o, sleep_o}, 4'h9);
    rd(2'h2, `UFC_ADDR_IER, 8'h00);
    rd(2'h2, `UFC_ADDR_MCR, 8'h14);
    rc(2'h2, 8'h00);
    $display("test gate done");
    tx_free_i[6:0] = 7'h05;
    rx_count_i[6:0] = 7'h09;
    wr(2'h1, `UFC_ADDR_MCR, 8'h04);
    wr(2'h1, `UFC_ADDR_TLR, 8'h21);
    wr(2'h1, `UFC_ADDR_TCR, 8'h33);
    rd(2'h1, `UFC_ADDR_TLR, 8'h00);
    rd(2'h1, `UFC_ADDR_TCR, 8'h00);
    rc(2'h1, 8'h12);
    wr(2'h1, `UFC_ADDR_MCR, 8'h44);
    wr(2'h1, `UFC_ADDR_TLR, 8'h21);
    rd(2'h1, `UFC_ADDR_TLR, 8'h21);
    rc(2'h1, 8'h13);
    rx_count_i[6:0] = 7'h08;
    rc(2'h1, 8'h03);
    rx_timeout_i[0] = 1'b1;
    rc(2'h1, 8'h13);
    rx_timeout_i[0] = 1'b0;
    wr(2'h1, `UFC_ADDR_RDY, 8'hc0);
    wr(2'h1, `UFC_ADDR_TLR, 8'h01);
    rx_count_i[6:0] = 7'h39;
    rc(2'h1, 8'h13);
    rx_count_i[6:0] = 7'h38;
    rc(2'h1, 8'h03);
    tx_free_i[6:0] = 7'h03;
    rc(2'h1, 8'h02);
    $display("test trigger done");
    wr(2'h1, `UFC_ADDR_TCR, 8'h4a);
    rd(2'h1, `UFC_ADDR_TCR, 8'h4a);
    wr(2'h1, `UFC_ADDR_EFR, 8'h50);
    foreach (lv[i]) begin
      rx_count_i[6:0] = lv[i];
      repeat (4) @(negedge clk_i);
      chk(rts_o[0], ex[i]);
    end
    $display("test rts done");
    wr(2'h1, `UFC_ADDR_EFR, 8'hb0);
    cts_i = 2'h3;
    pv(8'h14);
    chk({tx_halt_o, special_o}, 4'h4);
    pv(8'h13);
    chk(special_o, 2'h1);
    special_clear_i[0] = 1'b1;
    cts_i = 2'h0;
    @(negedge clk_i);
    special_clear_i[0] = 1'b0;
    repeat (6) @(negedge clk_i);
    chk({tx_halt_o, special_o}, 4'h0);
    $display("test cts and special done");
    tally_and_finish;
  end
endmodule // uart_flow_trigger_config_test

// ===== verification/ufc_chk.sv
// assertion checker for the flow, trigger and divisor block
`timescale 1ns/1ps
module ufc_chk
  import ufc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic [13:0] rx_count_i,
  input wire logic [13:0] tx_free_i,
  input wire logic [1:0] rx_timeout_i,
  input wire logic [1:0] rx_valid_i,
  input wire logic [15:0] rx_char_i,
  input wire logic [15:0] xoff2_char_i,
  input wire logic [1:0] special_clear_i,
  input wire logic data_oe_o,
  input wire logic [7:0] data_o,
  input wire logic [1:0] special_o,
  input wire logic [31:0] baud_divisor_o,
  input wire logic [7:0] fifo_ready_status_o
);
  // ****************************************
  // properties on channel a, the bus and both divisor words
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd_idle; rd_n_i [*4]; endsequence
  sequence s_wr_idle; wr_n_i [*8]; endsequence
  sequence s_rd_busy; (!rd_n_i && !(chip_select_a_n_i && chip_select_b_n_i)) [*4]; endsequence
  property p_oe_off; s_rd_idle |-> !data_oe_o && data_o == 8'h00; endproperty
  a_oe_off: assert property (p_oe_off) else $error("read enable without read");
  property p_oe_on; s_rd_busy |-> data_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("no read enable during read");
  property p_rdy_zero; fifo_ready_status_o[3:2] == 2'h0 && fifo_ready_status_o[7:6] == 2'h0; endproperty
  a_rdy_zero: assert property (p_rdy_zero) else $error("unused ready bits set");
  property p_tx_full; (tx_free_i[6:0] >= 7'h3c) [*5] |-> fifo_ready_status_o[0]; endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx ready low with free fifo");
  property p_tx_low; (tx_free_i[6:0] < 7'h04) [*3] |-> !fifo_ready_status_o[0]; endproperty
  a_tx_low: assert property (p_tx_low) else $error("tx ready high with no space");
  property p_rx_tmo; rx_timeout_i[0] [*5] |-> fifo_ready_status_o[4]; endproperty
  a_rx_tmo: assert property (p_rx_tmo) else $error("rx ready low on timeout");
  property p_rx_low; (rx_count_i[6:0] <= 7'h04 && !rx_timeout_i[0]) [*3] |-> !fifo_ready_status_o[4]; endproperty
  a_rx_low: assert property (p_rx_low) else $error("rx ready high below trigger");
  property p_spc_set;
    $rose(special_o[0]) |-> $past(rx_valid_i[0]) && $past(rx_char_i[7:0]) == $past(xoff2_char_i[7:0]);
  endproperty
  a_spc_set: assert property (p_spc_set) else $error("special flag without match");
  property p_spc_hold; special_o[0] && !special_clear_i[0] |=> special_o[0]; endproperty
  a_spc_hold: assert property (p_spc_hold) else $error("special flag lost");
  property p_div_hold; s_wr_idle |=> $stable(baud_divisor_o); endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor moved without write");
endmodule // ufc_chk
bind ufc_top ufc_chk i_chk (.*);

// ===== verification/ufc_host.sv
// host processor model driving the parallel register bus
`timescale 1ns/1ps
module ufc_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_a_n_o,
  output logic cs_b_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o
);
  // bus idle at time zero
  initial begin
    {cs_a_n_o, cs_b_n_o, wr_n_o, rd_n_o} = 4'hf;
    addr_o = 3'h0;
    data_o = 8'h00;
  end
  // one access: strobe four cycles, hold, then flip released lines
  task automatic go(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d, input logic w,
                    output logic [7:0] q);
    @(negedge clk_i);
    {cs_b_n_o, cs_a_n_o} = ~sel;
    addr_o = a;
    data_o = d;
    if (w) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    q = rdata_i;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    {cs_b_n_o, cs_a_n_o} = 2'h3;
    addr_o = ~a;
    data_o = ~d;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // ufc_host
